//--- rtl/twi_link_if.sv
// two-wire link between the master and the register port
`timescale 1ns/100ps
interface twi_link_if;
  logic scl_o;    // master clock drive level
  logic scl_oe;   // master pulls clock low while high
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;      // resolved wire levels, made by the bench
  logic sda;
  modport tgt (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport ctl (input scl, input sda, output scl_o, output scl_oe,
               output sda_m_o, output sda_m_oe);
endinterface

//--- rtl/twi_master.sv
// two-wire master end: one register write or read per request
`timescale 1ns/100ps
module twi_master
  import twi_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  twi_link_if.ctl          LINK,
  input  wire logic        REQ,
  input  wire logic        RD,
  input  wire logic [6:0]  DEV_ADDR,
  input  wire logic [3:0]  INDEX,
  input  wire logic [7:0]  WDATA,
  output logic             BUSY,
  output logic             DONE,
  output logic             NAK,
  output logic [7:0]       RDATA
);
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_BYTE  = 3'b010,
    M_STOP  = 3'b011,
    M_DONE  = 3'b100
  } mstate_t;

  mstate_t    state_r;
  logic [7:0] cnt_r;
  logic       tick;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic       rd_r;
  logic [6:0] dev_r;
  logic [3:0] idx_r;
  logic [7:0] wd_r;
  logic       scl_low_r;
  logic       sda_low_r;
  logic [1:0] sda_sync_r;

  // quarter-bit enable keeps the rate at standard mode
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) cnt_r <= 8'h00;
    else if (tick) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end
  assign tick = (cnt_r == QTR_CNT);

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) sda_sync_r <= 2'h3;
    else sda_sync_r <= {sda_sync_r[0], LINK.sda};
  end

  // bytes: 0 addr-write, 1 index, 2 data or addr-read, 3 read data
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= M_IDLE; ph_r <= 2'h0; bit_r <= 4'h0; byte_r <= 2'h0;
      sh_r <= 8'h00; rd_r <= 1'b0; dev_r <= 7'h00; idx_r <= 4'h0;
      wd_r <= 8'h00; scl_low_r <= 1'b0; sda_low_r <= 1'b0;
      DONE <= 1'b0; NAK <= 1'b0; RDATA <= 8'h00;
    end else begin
      DONE <= 1'b0;
      case (state_r)
        M_IDLE: if (REQ) begin
          rd_r <= RD; dev_r <= DEV_ADDR; idx_r <= INDEX; wd_r <= WDATA;
          NAK <= 1'b0; byte_r <= 2'h0; ph_r <= 2'h0;
          state_r <= M_START;
        end
        M_START: if (tick) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) begin
            scl_low_r <= 1'b0; sda_low_r <= 1'b0;
          end else if (ph_r == 2'h1) sda_low_r <= 1'b1;  // start
          else if (ph_r == 2'h2) begin
            scl_low_r <= 1'b1;
            sh_r <= (byte_r == 2'h0) ? {dev_r, 1'b0} : {dev_r, 1'b1};
            bit_r <= 4'h0; ph_r <= 2'h0; state_r <= M_BYTE;
          end
        end
        M_BYTE: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            // ack slot: release; after the one read byte that is the nak
            2'h0: sda_low_r <= (bit_r == BIT_ACK)
                     ? 1'b0 : (byte_r != 2'h3) & ~sh_r[7];
            2'h1: scl_low_r <= 1'b0;
            2'h2: if (bit_r == BIT_ACK) begin
                    if (byte_r != 2'h3 && sda_sync_r[1]) NAK <= 1'b1;
                  end else sh_r <= {sh_r[6:0], sda_sync_r[1]};
            default: begin
              scl_low_r <= 1'b1;
              if (bit_r != BIT_ACK) bit_r <= bit_r + 4'h1;
              else begin
                bit_r <= 4'h0;
                if (byte_r == 2'h3) RDATA <= sh_r;
                if (NAK || byte_r == 2'h3 || (byte_r == 2'h2 && !rd_r))
                  state_r <= M_STOP;
                else if (byte_r == 2'h1 && rd_r) begin
                  byte_r <= 2'h2; state_r <= M_START;  // restart
                end else begin
                  byte_r <= byte_r + 2'h1;
                  sh_r <= (byte_r == 2'h0) ? {4'h0, idx_r} : wd_r;
                end
              end
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) sda_low_r <= 1'b1;
          else if (ph_r == 2'h1) scl_low_r <= 1'b0;
          else if (ph_r == 2'h2) begin
            sda_low_r <= 1'b0; state_r <= M_DONE;  // stop
          end
        end
        M_DONE: begin
          DONE <= 1'b1; state_r <= M_IDLE;
        end
        default: state_r <= M_IDLE;
      endcase
    end
  end

  assign BUSY          = (state_r != M_IDLE);
  assign LINK.scl_o    = 1'b0;
  assign LINK.scl_oe   = scl_low_r;
  assign LINK.sda_m_o  = 1'b0;
  assign LINK.sda_m_oe = sda_low_r;
endmodule

//--- rtl/twi_pkg.sv
// shared constants for the two-wire register port and its master
package twi_pkg;
  localparam int          CLK_HZ          = 40000000;
  localparam int          BIT_RATE_BPS    = 100000;  // standard-mode limit
  // quarter of one bit period in system cycles (rounded down)
  localparam int          QTR_CYCLES      = CLK_HZ / (BIT_RATE_BPS * 4);
  localparam logic [7:0]  QTR_CNT         = 8'(QTR_CYCLES - 1);
  localparam logic [5:0]  ADDR_FIXED_HI   = 6'h16;   // upper six address bits
  localparam int          REG_IDX_W       = 4;
  localparam int          NUM_REGS        = 16;
  localparam logic [3:0]  BIT_LAST        = 4'h7;
  localparam logic [3:0]  BIT_ACK         = 4'h8;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
  localparam logic [3:0]  IDX_RESET_VAL   = 4'h0;
endpackage

//--- rtl/twi_target.sv
// register port: target end of the two-wire link
//
// Functional notes
// - target only, standard-mode rates
// - sda fall while scl high is start
// - sda rise while scl high is stop
// - sda changes only while scl low
// - first byte: address msb first, then direction
// - acknowledge only own address, ninth pulse
// - direction zero writes, one reads
// - eight data bits plus one acknowledge
// - transmitter releases sda in acknowledge slot
// - write: index byte then data bytes acknowledged
// - index upper nibble zero, lower selects register
// - several data bytes per write accepted
// - read: acknowledge own address, drive data
// - master acknowledges bytes it wants continued
// - master not-acknowledge ends read driving
// - address lsb copies strap pin
// - read: index write, then read restart
`timescale 1ns/100ps
module twi_target
  import twi_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  twi_link_if.tgt          LINK,
  input  wire logic        ADDR_SEL,
  output logic [7:0]       REG_DATA [NUM_REGS],
  output logic             WR_STROBE,
  output logic [3:0]       WR_INDEX
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_INDEX = 3'b010,
    S_WDATA = 3'b011,
    S_RDATA = 3'b100,
    S_IGNORE= 3'b101
  } tstate_t;

  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  tstate_t    state_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic [3:0] index_r;
  logic       ack_phase_r;
  logic       master_nak_r;
  logic       sda_low_r;
  logic [7:0] regs_r [NUM_REGS];
  logic       addr_sel_r;
  logic       addr_sel_meta_r;
  logic       skip_fall_r;
  logic       bit_end;

  // two flops before use; third flop is for edge finding only
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], LINK.scl};
      sda_sync_r <= {sda_sync_r[1:0], LINK.sda};
    end
  end

  // strap pin may move at any time: two flops before use
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_sel_meta_r <= 1'b0;
      addr_sel_r      <= 1'b0;
    end else begin
      addr_sel_meta_r <= ADDR_SEL;
      addr_sel_r      <= addr_sel_meta_r;
    end
  end

  // edges from the second and third flops
  assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
  // start/stop: sda moves while scl high
  assign start_det = scl_sync_r[1] & scl_sync_r[2]
                     & sda_sync_r[2] & ~sda_sync_r[1];
  assign stop_det  = scl_sync_r[1] & scl_sync_r[2]
                     & ~sda_sync_r[2] & sda_sync_r[1];

  // the scl fall that closes a start carries no bit
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      skip_fall_r <= 1'b0;
    end else if (start_det) begin
      skip_fall_r <= 1'b1;
    end else if (stop_det || scl_fall) begin
      skip_fall_r <= 1'b0;
    end
  end
  // bit boundary: a scl fall that ends a data or ack bit
  assign bit_end = scl_fall & ~skip_fall_r;

  // protocol engine: bits sampled on scl rise, sda moved on scl fall
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r      <= S_IDLE;
      bit_r        <= 4'h0;
      shift_r      <= REG_RESET_VAL;
      index_r      <= IDX_RESET_VAL;
      ack_phase_r  <= 1'b0;
      master_nak_r <= 1'b0;
      sda_low_r    <= 1'b0;
      WR_STROBE    <= 1'b0;
      WR_INDEX     <= IDX_RESET_VAL;
    end else begin
      WR_STROBE <= 1'b0;
      if (start_det) begin
        state_r     <= S_ADDR;
        bit_r       <= 4'h0;
        ack_phase_r <= 1'b0;
        sda_low_r   <= 1'b0;
      end else if (stop_det) begin
        state_r   <= S_IDLE;
        sda_low_r <= 1'b0;
      end else if (state_r != S_IDLE && state_r != S_IGNORE) begin
        if (scl_rise) begin
          // sample on rise: sda is stable through scl high
          if (bit_r == BIT_ACK) begin
            master_nak_r <= sda_sync_r[1];
          end else if (state_r != S_RDATA) begin
            // in a read the shifter feeds sda, so no sampling back
            shift_r <= {shift_r[6:0], sda_sync_r[1]};
          end
        end else if (bit_end) begin
          // eighth bit done: the ninth pulse is the acknowledge
          if (bit_r == BIT_LAST) begin
            bit_r <= BIT_ACK;
            case (state_r)
              S_ADDR: begin
                if (shift_r[7:1] == {ADDR_FIXED_HI, addr_sel_r}) begin
                  sda_low_r <= 1'b1;
                  state_r <= shift_r[0] ? S_RDATA : S_INDEX;
                end else begin
                  sda_low_r <= 1'b0;
                  state_r   <= S_IGNORE;
                end
              end
              S_INDEX: begin
                sda_low_r <= 1'b1;
                index_r   <= shift_r[3:0];
                state_r   <= S_WDATA;
              end
              S_WDATA: begin
                sda_low_r <= 1'b1;
                WR_STROBE <= 1'b1;
                WR_INDEX  <= index_r;
                index_r   <= index_r + 4'h1;
              end
              S_RDATA: sda_low_r <= 1'b0;
              default: sda_low_r <= 1'b0;
            endcase
          end else if (bit_r == BIT_ACK) begin
            bit_r <= 4'h0;
            if (state_r == S_RDATA) begin
              if (ack_phase_r && master_nak_r) begin
                state_r   <= S_IGNORE;
                sda_low_r <= 1'b0;
              end else begin
                // load next byte, drive its msb
                shift_r     <= regs_r[index_r];
                sda_low_r   <= ~regs_r[index_r][7];
                index_r     <= index_r + 4'h1;
                ack_phase_r <= 1'b1;
              end
            end else begin
              sda_low_r <= 1'b0;
            end
          end else begin
            bit_r <= bit_r + 4'h1;
            if (state_r == S_RDATA) begin
              // next bit out a few cycles after scl fell
              sda_low_r <= ~shift_r[6];
              shift_r   <= {shift_r[6:0], 1'b1};
            end
          end
        end
      end
    end
  end

  // register store written by each acknowledged data byte
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < NUM_REGS; i++) regs_r[i] <= REG_RESET_VAL;
    end else if (state_r == S_WDATA && bit_end && bit_r == BIT_LAST
                 && !start_det && !stop_det) begin
      regs_r[index_r] <= shift_r;
    end
  end

  assign REG_DATA      = regs_r;
  // open drain: only ever pulls low, never drives scl
  assign LINK.sda_s_o  = 1'b0;
  assign LINK.sda_s_oe = sda_low_r;
endmodule

//--- verif/testbench.sv
// self-checking bench: master and register port joined on one link
`timescale 1ns/100ps
module testbench;
  import twi_pkg::*;
  typedef struct packed {
    logic       rd;
    logic       nak;
    logic [3:0] idx;
    logic [7:0] val;
  } note_t;
  logic       clk, rst, sel, req, rd, busy, done, nak, wr_strobe;
  logic [6:0] dev_addr;
  logic [3:0] index, wr_index;
  logic [7:0] wdata, rdata, d0, d1;
  logic [7:0] reg_data [NUM_REGS];
  note_t      notes [$];
  logic [3:0] widx [$];
  int         mismatches, n_tests, cycles, seed;
  twi_link_if link();
  // pull-ups resolve the open-drain wires
  assign link.scl = ~link.scl_oe;
  assign link.sda = ~(link.sda_m_oe | link.sda_s_oe);
  twi_master u_twi_master (.CLOCK(clk), .SYS_RST(rst), .LINK(link),
    .REQ(req), .RD(rd), .DEV_ADDR(dev_addr), .INDEX(index), .WDATA(wdata),
    .BUSY(busy), .DONE(done), .NAK(nak), .RDATA(rdata));
  twi_target u_twi_target (.CLOCK(clk), .SYS_RST(rst), .LINK(link),
    .ADDR_SEL(sel), .REG_DATA(reg_data), .WR_STROBE(wr_strobe),
    .WR_INDEX(wr_index));
  twi_link_assertions u_twi_link_assertions (.CLOCK(clk), .SYS_RST(rst),
    .scl(link.scl), .sda(link.sda), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one master request; notes what the watcher must see
  task automatic xfer(input logic r, input logic [6:0] a,
                      input logic [3:0] i, input logic [7:0] d, e);
    logic hit;
    hit = (a === {ADDR_FIXED_HI, sel});
    notes.push_back('{r, !hit, i, e});
    if (hit && !r) widx.push_back(i);
    @(negedge clk);
    rd = r;
    dev_addr = a;
    index = i;
    wdata = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    while (busy !== 1'b0) @(negedge clk);
    repeat (2) @(negedge clk);
    chk("link idle", 8'h03, {6'h00, link.scl, link.sda});
  endtask
  // hang guard, well above five frames
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      results();
    end
  end
  // watcher: pops the oldest note on each result
  always @(negedge clk) begin : watch
    note_t n;
    if (done === 1'b1) begin
      if (notes.size() == 0) chk("spurious done", 8'h00, 8'h01);
      else begin
        n = notes.pop_front();
        chk("nak", {7'h00, n.nak}, {7'h00, nak});
        if (!n.nak && n.rd) chk("read data", n.val, rdata);
        if (!n.nak && !n.rd) chk("reg", n.val, reg_data[n.idx]);
      end
    end
    if (wr_strobe === 1'b1) begin
      if (widx.size() == 0) chk("spurious write", 8'h00, 8'h01);
      else chk("wr index", {4'h0, widx.pop_front()}, {4'h0, wr_index});
    end
  end
  initial begin
    seed = 87589;
    cycles = 0;
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    sel = 1'b0;
    req = 1'b0;
    rd = 1'b0;
    dev_addr = 7'h00;
    index = 4'h0;
    wdata = 8'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    xfer(1'b0, {ADDR_FIXED_HI, 1'b0}, 4'h0, d0, d0);
    sel = 1'b1;
    xfer(1'b0, {ADDR_FIXED_HI, 1'b1}, 4'hF, d1, d1);
    xfer(1'b0, {ADDR_FIXED_HI, 1'b0}, 4'h0, ~d0, 8'h00);
    xfer(1'b1, {ADDR_FIXED_HI, 1'b1}, 4'hF, 8'h00, d1);
    xfer(1'b1, {ADDR_FIXED_HI, 1'b1}, 4'h0, 8'h00, d0);
    chk("left over", 8'h00, 8'(notes.size() + widx.size()));
    results();
  end
endmodule

//--- verif/twi_link_assertions.sv
// protocol checker for the target side of the two-wire link
`timescale 1ns/100ps
module twi_link_assertions (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        scl,
  input wire logic        sda,
  input wire logic        sda_s_o,
  input wire logic        sda_s_oe
);
  logic [3:0]  rise_r;
  logic [12:0] hold_r;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence start_s; scl && $fell(sda); endsequence
  sequence stop_s; scl && $rose(sda); endsequence
  // clock pulses since the last start, saturating at 15
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) rise_r <= 4'h0;
    else if (scl && $fell(sda)) rise_r <= 4'h0;
    else if ($rose(scl) && rise_r != 4'hF) rise_r <= rise_r + 4'h1;
  end
  // length of one unbroken pull; caps a stuck driver
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) hold_r <= 13'h0000;
    else if (!sda_s_oe) hold_r <= 13'h0000;
    else if (hold_r != 13'h1FFF) hold_r <= hold_r + 13'h0001;
  end
  a_target_open_drain: assert property (sda_s_oe |-> sda_s_o == 1'b0)
    else $error("target drives a high level");
  a_drive_stable_high: assert property (scl && $past(scl) |->
    $stable(sda_s_oe)) else $error("target data moved while clock high");
  a_drive_rise_low: assert property ($rose(sda_s_oe) |->
    !scl && $past(!scl, 2)) else $error("target pull began near clock high");
  a_ack_holds_high: assert property ($rose(scl) && sda_s_oe |->
    sda_s_oe [*8]) else $error("target pull dropped in clock high");
  a_addr_ack_slot: assert property ($rose(scl) && sda_s_oe &&
    rise_r < 4'h9 |-> rise_r == 4'h8) else $error("address ack misplaced");
  a_start_quiet: assert property (start_s |=> !sda_s_oe [*8])
    else $error("target pulls right after start");
  a_stop_release: assert property (stop_s |=> !sda_s_oe [*8])
    else $error("target pulls right after stop");
  a_drive_bounded: assert property (hold_r < 13'd4000)
    else $error("target held the data line past nine slots");
endmodule
